// *** hdl/dpl_lock.sv ***
// Probe access lock: mode, key, boot and status registers plus probe gate.
// Assumes a one-cycle register port master and a separate power-on reset input.
//
// The strobed register port was decided locally.
`include "dpl_defines.svh"
module dpl_lock
   import dpl_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              reset,
   input  wire logic              por,
   input  wire dpl_pkg::dpl_word_t reg_addr,
   input  wire dpl_pkg::dpl_word_t reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output      dpl_pkg::dpl_word_t reg_rdata,
   input  wire logic              flash_rd_protect,
   input  wire logic              probe_req_pin,
   input  wire logic              probe_flash_rd_pin,
   output      logic              probe_grant,
   output      logic              probe_refuse,
   output      logic              probe_inhibit,
   output      logic              flash_user_boot
);
   import dpl_pkg::*;

   dpl_gate_if gif ();

   logic            mode_disable_q;
   logic            inhibit_q;
   dpl_flash_mode_t flash_mode_q;
   logic            key_err_q;
   logic            refused_q;
   dpl_word_t       rdata_q;
   logic            wr_mode;
   logic            wr_key;
   logic            wr_boot;
   logic            wr_status;
   logic            key_good;

   // Address match for a given register
   function automatic logic hit(input dpl_word_t a, input dpl_word_t r);
      return a == r;
   endfunction : hit

   assign wr_mode   = reg_wr && hit(reg_addr, `DPL_ADDR_MODE);
   assign wr_key    = reg_wr && hit(reg_addr, `DPL_ADDR_KEY);
   assign wr_boot   = reg_wr && hit(reg_addr, `DPL_ADDR_BOOT);
   assign wr_status = reg_wr && hit(reg_addr, `DPL_ADDR_STATUS);
   assign key_good  = wr_key && reg_wdata == `DPL_KEY_WORD;

   // Mode register: power-on reset only, ordinary reset keeps it
   always_ff @(posedge mclk) begin
      if (por) begin
         mode_disable_q <= `DPL_MODE_RESET;
      end else if (wr_mode) begin
         mode_disable_q <= reg_wdata[`DPL_BIT_DISABLE];
      end
   end

   // Live inhibit follows the mode bit only on a good key
   always_ff @(posedge mclk) begin
      if (por) begin
         inhibit_q <= `DPL_MODE_RESET;
      end else if (key_good) begin
         inhibit_q <= mode_disable_q;
      end
   end

   // Flash mode: software may enter user boot, every reset returns normal
   always_ff @(posedge mclk) begin
      if (reset || por) begin
         flash_mode_q <= DPL_FLASH_NORMAL;
      end else if (wr_boot) begin
         flash_mode_q <= reg_wdata[`DPL_BIT_USERBOOT] ? DPL_FLASH_USER_BOOT
                                                       : DPL_FLASH_NORMAL;
      end
   end

   // Sticky status: set wins over write-one-to-clear
   always_ff @(posedge mclk) begin
      if (reset || por) begin
         key_err_q <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         if (wr_key && !key_good) begin
            key_err_q <= 1'b1;
         end else if (wr_status && reg_wdata[`DPL_BIT_KEYERR]) begin
            key_err_q <= 1'b0;
         end
         if (gif.probe_refuse) begin
            refused_q <= 1'b1;
         end else if (wr_status && reg_wdata[`DPL_BIT_REFUSED]) begin
            refused_q <= 1'b0;
         end
      end
   end

   // Read data one cycle after the strobe, zero elsewhere
   always_ff @(posedge mclk) begin
      if (reset || por) begin
         rdata_q <= `DPL_READ_ZERO;
      end else begin
         rdata_q <= `DPL_READ_ZERO;
         if (reg_rd) begin
            unique case (reg_addr)
               `DPL_ADDR_MODE: begin
                  rdata_q[`DPL_BIT_DISABLE] <= mode_disable_q;
               end
               `DPL_ADDR_BOOT: begin
                  rdata_q[`DPL_BIT_USERBOOT] <= flash_mode_q == DPL_FLASH_USER_BOOT;
               end
               `DPL_ADDR_STATUS: begin
                  rdata_q[`DPL_BIT_INHIBIT] <= inhibit_q;
                  rdata_q[`DPL_BIT_KEYERR]  <= key_err_q;
                  rdata_q[`DPL_BIT_REFUSED] <= refused_q;
               end
               default: begin
                  rdata_q <= `DPL_READ_ZERO;
               end
            endcase
         end
      end
   end

   assign gif.probe_inhibit    = inhibit_q;
   assign gif.flash_rd_protect = flash_rd_protect;

   dpl_probe_gate u_gate (
      .mclk               (mclk),
      .reset              (reset || por),
      .probe_req_pin      (probe_req_pin),
      .probe_flash_rd_pin (probe_flash_rd_pin),
      .gif                (gif.gate)
   );

   assign probe_grant     = gif.probe_grant;
   assign probe_refuse    = gif.probe_refuse;
   assign probe_inhibit   = inhibit_q;
   assign flash_user_boot = flash_mode_q == DPL_FLASH_USER_BOOT;
   assign reg_rdata       = rdata_q;

   property p_key_unlock;
      @(posedge mclk) disable iff (reset || por)
      key_good && !mode_disable_q |=> !inhibit_q;
   endproperty
   a_key_unlock: assert property (p_key_unlock)
      else $error("good key with bit clear did not unlock");

   property p_key_rearm;
      @(posedge mclk) disable iff (reset || por)
      key_good && mode_disable_q |=> inhibit_q;
   endproperty
   a_key_rearm: assert property (p_key_rearm)
      else $error("good key with bit set did not re-arm");

   property p_bad_key;
      @(posedge mclk) disable iff (reset || por)
      !key_good |=> $stable(inhibit_q);
   endproperty
   a_bad_key: assert property (p_bad_key)
      else $error("inhibit changed without a good key");

   property p_unlock_needs_bit;
      @(posedge mclk) disable iff (reset || por)
      $fell(inhibit_q) |-> $past(key_good) && !$past(mode_disable_q);
   endproperty
   a_unlock_needs_bit: assert property (p_unlock_needs_bit)
      else $error("inhibit lifted without both steps");

   property p_por_mode;
      @(posedge mclk) por |=> mode_disable_q && inhibit_q;
   endproperty
   a_por_mode: assert property (p_por_mode)
      else $error("power-on reset did not set disable");

   property p_mode_keep;
      @(posedge mclk) disable iff (por)
      reset |=> $stable(mode_disable_q) && $stable(inhibit_q);
   endproperty
   a_mode_keep: assert property (p_mode_keep)
      else $error("ordinary reset changed mode register");

   property p_boot_normal;
      @(posedge mclk) reset |=> !flash_user_boot;
   endproperty
   a_boot_normal: assert property (p_boot_normal)
      else $error("reset left flash in user boot");

   property p_mode_read;
      @(posedge mclk) disable iff (reset || por)
      reg_rd && reg_addr == `DPL_ADDR_MODE
         |=> reg_rdata == {31'h0000_0000, $past(mode_disable_q)};
   endproperty
   a_mode_read: assert property (p_mode_read)
      else $error("mode read wrong");

   property p_key_read_zero;
      @(posedge mclk) disable iff (reset || por)
      reg_rd && reg_addr == `DPL_ADDR_KEY |=> reg_rdata == `DPL_READ_ZERO;
   endproperty
   a_key_read_zero: assert property (p_key_read_zero)
      else $error("key register read not zero");

   // Sticky flags, mode bit writes and boot mode entry
   property p_key_err_set;
      @(posedge mclk) disable iff (reset || por)
      wr_key && !key_good |=> key_err_q && $stable(inhibit_q);
   endproperty
   a_key_err_set: assert property (p_key_err_set)
      else $error("wrong key not flagged or changed inhibit");

   property p_mode_clear;
      @(posedge mclk) disable iff (reset || por)
      wr_mode && !reg_wdata[`DPL_BIT_DISABLE] |=> !mode_disable_q;
   endproperty
   a_mode_clear: assert property (p_mode_clear)
      else $error("mode bit not cleared by write");

   property p_refused_sticky;
      @(posedge mclk) disable iff (reset || por)
      gif.probe_refuse |=> refused_q;
   endproperty
   a_refused_sticky: assert property (p_refused_sticky)
      else $error("refused probe access not recorded");

   property p_boot_enter;
      @(posedge mclk) disable iff (reset || por)
      wr_boot && reg_wdata[`DPL_BIT_USERBOOT] |=> flash_user_boot;
   endproperty
   a_boot_enter: assert property (p_boot_enter)
      else $error("software could not enter user boot");

   c_unlock: cover property (@(posedge mclk) disable iff (reset || por) $fell(inhibit_q));
   c_rearm:  cover property (@(posedge mclk) disable iff (reset || por) $rose(inhibit_q));
   c_grant:  cover property (@(posedge mclk) disable iff (reset || por) probe_grant);
endmodule : dpl_lock

// *** hdl/dpl_defines.svh ***
// Constants for the debug probe access lock: register map, fields, reset values.
// Assumes a plain register port with 32-bit word accesses and one core clock.
`ifndef DPL_DEFINES_SVH
`define DPL_DEFINES_SVH
`define DPL_ADDR_MODE     32'hFFFF_E510
`define DPL_ADDR_KEY      32'hFFFF_E514
`define DPL_ADDR_BOOT     32'hFFFF_E518
`define DPL_ADDR_STATUS   32'hFFFF_E51C
`define DPL_KEY_WORD      32'h0000_00C5
`define DPL_MODE_RESET    1'h1
`define DPL_BIT_DISABLE   0
`define DPL_BIT_USERBOOT  0
`define DPL_BIT_INHIBIT   0
`define DPL_BIT_KEYERR    1
`define DPL_BIT_REFUSED   2
`define DPL_READ_ZERO     32'h0000_0000
`endif

// *** hdl/dpl_pkg.sv ***
// Types shared by the probe lock modules.
// Assumes dpl_defines.svh supplies the numeric constants.
package dpl_pkg;
   typedef logic [31:0] dpl_word_t;
   typedef enum logic {DPL_FLASH_NORMAL, DPL_FLASH_USER_BOOT} dpl_flash_mode_t;
endpackage : dpl_pkg

// *** hdl/dpl_gate_if.sv ***
// Signals between the lock registers and the probe gate.
// Assumes both ends run on mclk.
interface dpl_gate_if;
   logic probe_inhibit;
   logic flash_rd_protect;
   logic probe_grant;
   logic probe_refuse;
   modport lock (output probe_inhibit, output flash_rd_protect,
                 input probe_grant, input probe_refuse);
   modport gate (input probe_inhibit, input flash_rd_protect,
                 output probe_grant, output probe_refuse);
endinterface : dpl_gate_if

// *** hdl/dpl_probe_gate.sv ***
// Probe gate: synchronises debug-port requests and grants or refuses them.
// Assumes probe pins are asynchronous to mclk and held for the access.
module dpl_probe_gate
   import dpl_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic probe_req_pin,
   input wire logic probe_flash_rd_pin,
   dpl_gate_if.gate gif
);
   import dpl_pkg::*;

   logic [1:0] req_sync_q;
   logic [1:0] rd_sync_q;
   logic       grant_q;
   logic       refuse_q;
   logic       allowed;

   // Two-stage synchronisers on the probe pins
   always_ff @(posedge mclk) begin
      if (reset) begin
         req_sync_q <= 2'h0;
         rd_sync_q  <= 2'h0;
      end else begin
         req_sync_q <= {req_sync_q[0], probe_req_pin};
         rd_sync_q  <= {rd_sync_q[0], probe_flash_rd_pin};
      end
   end

   // Inhibit blocks all, read protect blocks flash reads
   assign allowed = !gif.probe_inhibit
                    && !(rd_sync_q[1] && gif.flash_rd_protect);

   // Registered answer while a request stands
   always_ff @(posedge mclk) begin
      if (reset) begin
         grant_q  <= 1'b0;
         refuse_q <= 1'b0;
      end else begin
         grant_q  <= req_sync_q[1] && allowed;
         refuse_q <= req_sync_q[1] && !allowed;
      end
   end

   assign gif.probe_grant  = grant_q;
   assign gif.probe_refuse = refuse_q;

   property p_no_grant_inhibit;
      @(posedge mclk) disable iff (reset)
      grant_q |-> !$past(gif.probe_inhibit);
   endproperty
   a_no_grant_inhibit: assert property (p_no_grant_inhibit)
      else $error("probe granted while inhibited");

   property p_no_flash_read;
      @(posedge mclk) disable iff (reset)
      grant_q |-> !($past(rd_sync_q[1]) && $past(gif.flash_rd_protect));
   endproperty
   a_no_flash_read: assert property (p_no_flash_read)
      else $error("protected flash read granted");

   c_refused: cover property (@(posedge mclk) disable iff (reset) refuse_q);
endmodule : dpl_probe_gate

// *** tb/dpl_probe_model.sv ***
// Debug probe stand-in on the debug port: raises request and flash-read pins.
// Assumes the bench sets the request level; pins change only after a rising mclk edge.
module dpl_probe_model (
   input  wire logic mclk,
   input  wire logic req_lvl,
   input  wire logic flash_lvl,
   output      logic probe_req_pin,
   output      logic probe_flash_rd_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   logic req_q   = 1'b0;
   logic flash_q = 1'b0;

   // Request follows the bench; an idle kind pin toggles so no stale value is seen
   always @(posedge mclk) begin
      req_q   <= req_lvl;
      flash_q <= req_lvl ? flash_lvl : ~flash_q;
   end

   assign probe_req_pin      = req_q;
   assign probe_flash_rd_pin = flash_q;
endmodule : dpl_probe_model

// *** tb/dpl_lock_bench.sv ***
// Self-checking bench for the probe access lock: register tasks and probe requests.
// Assumes read data one cycle after the strobe and probe answers within 5 cycles.
`include "dpl_defines.svh"
module dpl_lock_bench
   import dpl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic      mclk = 1'b0, reset = 1'b1, por = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic      flash_rd_protect = 1'b0, req_lvl = 1'b0, flash_lvl = 1'b0;
   dpl_word_t reg_addr = 32'h0000_0000, reg_wdata = 32'h0000_0000, reg_rdata;
   logic      probe_req_pin, probe_flash_rd_pin, probe_grant, probe_refuse;
   logic      probe_inhibit, flash_user_boot;
   int        error_cnt = 0, n_tests = 0, cycles = 0;

   dpl_lock dut (.mclk(mclk), .reset(reset), .por(por), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .flash_rd_protect(flash_rd_protect), .probe_req_pin(probe_req_pin),
      .probe_flash_rd_pin(probe_flash_rd_pin), .probe_grant(probe_grant),
      .probe_refuse(probe_refuse), .probe_inhibit(probe_inhibit),
      .flash_user_boot(flash_user_boot));
   dpl_probe_model probe_far (.mclk(mclk), .req_lvl(req_lvl), .flash_lvl(flash_lvl),
      .probe_req_pin(probe_req_pin), .probe_flash_rd_pin(probe_flash_rd_pin));

   // Clock at 25 MHz
   initial begin
      forever #20 mclk = ~mclk;
   end

   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 4000) begin
         error_cnt++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test

   task automatic check(input string what, input dpl_word_t seen, input dpl_word_t exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Full 32-bit word write, one strobe cycle
   task automatic wr(input dpl_word_t a, input dpl_word_t d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input string what, input dpl_word_t a, input dpl_word_t exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 check(what, reg_rdata, exp);
   endtask : rd

   task automatic probe(input logic fl, input logic eg, input logic er);
      @(posedge mclk);
      req_lvl   <= 1'b1;
      flash_lvl <= fl;
      repeat (5) @(posedge mclk);
      #1 check("grant", 32'(probe_grant), 32'(eg));
      check("refuse", 32'(probe_refuse), 32'(er));
      @(posedge mclk);
      req_lvl <= 1'b0;
      repeat (6) @(posedge mclk);
      #1 check("grant_idle", 32'(probe_grant | probe_refuse), 32'h0000_0000);
   endtask : probe

   task automatic pulse_reset(input logic p);
      @(posedge mclk);
      reset <= 1'b1;
      por   <= p;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      por   <= 1'b0;
   endtask : pulse_reset

   // Main sequence
   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      por   <= 1'b0;
      rd("mode_por", `DPL_ADDR_MODE, 32'h0000_0001);
      check("inh_por", 32'(probe_inhibit), 32'h0000_0001);
      rd("key_read", `DPL_ADDR_KEY, 32'h0000_0000);
      rd("unmapped", 32'hFFFF_E520, 32'h0000_0000);
      probe(1'b0, 1'b0, 1'b1);
      wr(`DPL_ADDR_MODE, 32'h0000_0000);
      check("inh_nokey", 32'(probe_inhibit), 32'h0000_0001);
      wr(`DPL_ADDR_KEY, 32'h0000_00C4);
      check("inh_badkey", 32'(probe_inhibit), 32'h0000_0001);
      rd("status_err", `DPL_ADDR_STATUS, 32'h0000_0007);
      wr(`DPL_ADDR_STATUS, 32'h0000_0006);
      rd("status_clr", `DPL_ADDR_STATUS, 32'h0000_0001);
      wr(`DPL_ADDR_KEY, `DPL_KEY_WORD);
      check("inh_unlock", 32'(probe_inhibit), 32'h0000_0000);
      probe(1'b0, 1'b1, 1'b0);
      @(posedge mclk) flash_rd_protect <= 1'b1;
      probe(1'b1, 1'b0, 1'b1);
      probe(1'b0, 1'b1, 1'b0);
      @(posedge mclk) flash_rd_protect <= 1'b0;
      probe(1'b1, 1'b1, 1'b0);
      wr(`DPL_ADDR_MODE, 32'hFFFF_FFFE);
      rd("mode_upper", `DPL_ADDR_MODE, 32'h0000_0000);
      wr(`DPL_ADDR_MODE, 32'hFFFF_FFFF);
      rd("mode_set", `DPL_ADDR_MODE, 32'h0000_0001);
      check("inh_pending", 32'(probe_inhibit), 32'h0000_0000);
      wr(`DPL_ADDR_BOOT, 32'h0000_0001);
      check("user_boot", 32'(flash_user_boot), 32'h0000_0001);
      rd("boot_rd", `DPL_ADDR_BOOT, 32'h0000_0001);
      pulse_reset(1'b0);
      #1 check("boot_rst", 32'(flash_user_boot), 32'h0000_0000);
      check("inh_rst", 32'(probe_inhibit), 32'h0000_0000);
      rd("boot_rd_rst", `DPL_ADDR_BOOT, 32'h0000_0000);
      rd("mode_rst", `DPL_ADDR_MODE, 32'h0000_0001);
      wr(`DPL_ADDR_KEY, `DPL_KEY_WORD);
      check("inh_rearm", 32'(probe_inhibit), 32'h0000_0001);
      probe(1'b0, 1'b0, 1'b1);
      wr(`DPL_ADDR_MODE, 32'h0000_0000);
      wr(`DPL_ADDR_KEY, `DPL_KEY_WORD);
      check("inh_again", 32'(probe_inhibit), 32'h0000_0000);
      pulse_reset(1'b1);
      #1 check("inh_por2", 32'(probe_inhibit), 32'h0000_0001);
      rd("mode_por2", `DPL_ADDR_MODE, 32'h0000_0001);
      finish_test();
   end
endmodule : dpl_lock_bench
